// File: cti_pkg.sv
`default_nettype none
package cti_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int           CNT_W       = 8;
  localparam logic [7:0]   CNT_RST     = 8'h00;
  localparam int           DIV_W       = 7;
  localparam logic [6:0]   DIV_RST     = 7'h00;
  localparam int           FILT_DEPTH  = 5;
  // ****************************************
  // Prescaler tap positions (level of the divided clock)
  // ****************************************
  localparam int           TAP_DIV64   = 5;
  localparam int           TAP_DIV32   = 4;
  localparam int           TAP_DIV2    = 0;
  // ****************************************
  // Clock select codes {hi, lo}
  // ****************************************
  localparam logic [1:0]   CKS_DIV64   = 2'h0;
  localparam logic [1:0]   CKS_DIV32   = 2'h1;
  localparam logic [1:0]   CKS_DIV2    = 2'h2;
  localparam logic [1:0]   CKS_SUB2    = 2'h3;
endpackage
`default_nettype wire

// File: cti_input_path.sv
// What this block does
// - Counter increments on each falling edge of the selected internal clock, except in a cycle where it clears.
// - A select change taking the clock from high to low counts once.
// - Pin-function bit set while pin high yields a rising capture edge.
// - Pin-function bit cleared while pin high yields a falling capture edge.
// - Filter enable then early pin-function change yields false capture edges.
// - Unassigned capture pin presents a constant low capture signal while the filter is off.
// - Filter disabled early after pin change yields matching false edge.
// - Any edge matching the interrupt edge select sets the request flag.
// - Filter of five sampled latches updates only when all agree or when enabling seeds it.
// - With filter on, capture pulses lag the pin by six samples.
// - Rising edge copies counter to rise register, falling to fall register.
// - Counter clears on rising, falling or both edges per clear-select bits.
`timescale 1ns/1ps
`default_nettype none
module cti_input_path (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  // Capture pin and watch clock level
  input  wire logic                  i_capture_pin_port,
  input  wire logic                  i_sub_clock_half,
  // Port mode bits
  input  wire logic                  i_capture_pin_select,
  input  wire logic                  i_filter_enable,
  // Timer mode bits
  input  wire logic                  i_clock_select_hi,
  input  wire logic                  i_clock_select_lo,
  input  wire logic                  i_counter_clear_select_hi,
  input  wire logic                  i_counter_clear_select_lo,
  input  wire logic                  i_interrupt_edge_select,
  // Software flag clear
  input  wire logic                  i_irq_flag_clear,
  // Timer state
  output logic [cti_pkg::CNT_W-1:0]  o_capture_counter,
  output logic [cti_pkg::CNT_W-1:0]  o_rise_capture_reg,
  output logic [cti_pkg::CNT_W-1:0]  o_fall_capture_reg,
  output logic                       o_capture_irq_flag,
  output logic                       o_capture_signal
);
  // ****************************************
  // Count clock
  // ****************************************
  logic [cti_pkg::DIV_W-1:0] div_ff;
  logic                      selclk_ff;
  wire  logic [1:0]          clk_sel = {i_clock_select_hi, i_clock_select_lo};
  wire  logic                sel_clk =
    (clk_sel == cti_pkg::CKS_DIV64) ? div_ff[cti_pkg::TAP_DIV64] :
    (clk_sel == cti_pkg::CKS_DIV32) ? div_ff[cti_pkg::TAP_DIV32] :
    (clk_sel == cti_pkg::CKS_DIV2)  ? div_ff[cti_pkg::TAP_DIV2]  :
                                      i_sub_clock_half;
  // Muxed level is registered, so a switchover high to low counts too
  wire  logic                sel_fall = selclk_ff & ~sel_clk;
  wire  logic                sel_rise = ~selclk_ff & sel_clk;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_ff    <= cti_pkg::DIV_RST;
      selclk_ff <= 1'b0;
    end else begin
      div_ff    <= div_ff + 7'h01;
      selclk_ff <= sel_clk;
    end
  end

  // ****************************************
  // Pin gating and noise filter
  // ****************************************
  logic [cti_pkg::FILT_DEPTH-1:0] lat_ff;
  logic                           filt_ff;
  logic                           fen_ff;
  wire  logic pin_gated   = i_capture_pin_select & i_capture_pin_port;
  // Filter off samples on every system clock
  wire  logic samp_tick   = i_filter_enable ? sel_rise : 1'b1;
  wire  logic fen_rise    = i_filter_enable & ~fen_ff;
  wire  logic lat_all_hi  = &lat_ff;
  wire  logic lat_all_lo  = ~|lat_ff;
  // Enabling seeds the filter opposite to the pin; an early pin-function
  // change then shows up as a false edge, as on the real part
  wire  logic seed_lvl    = ~i_capture_pin_port;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lat_ff  <= '0;
      filt_ff <= 1'b0;
      fen_ff  <= 1'b0;
    end else begin
      fen_ff <= i_filter_enable;
      if (fen_rise) begin
        lat_ff  <= {cti_pkg::FILT_DEPTH{seed_lvl}};
        filt_ff <= seed_lvl;
      end else if (samp_tick) begin
        lat_ff <= {lat_ff[cti_pkg::FILT_DEPTH-2:0], pin_gated};
        if (lat_all_hi) begin
          filt_ff <= 1'b1;
        end else if (lat_all_lo) begin
          filt_ff <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Capture signal and edge detect
  // ****************************************
  logic cap_ff;
  logic cap_prev_ff;
  // Bypass on filter off: a direct switch exposes pin changes at once
  wire  logic cap_next = i_filter_enable ? filt_ff : pin_gated;
  wire  logic edge_rise = cap_ff & ~cap_prev_ff;
  wire  logic edge_fall = ~cap_ff & cap_prev_ff;
  wire  logic edge_hit  = i_interrupt_edge_select ? edge_rise : edge_fall;
  wire  logic clr_now   = (edge_rise & i_counter_clear_select_hi) |
                          (edge_fall & i_counter_clear_select_lo);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cap_ff      <= 1'b0;
      cap_prev_ff <= 1'b0;
    end else begin
      cap_ff      <= cap_next;
      cap_prev_ff <= cap_ff;
    end
  end

  // ****************************************
  // Counter, capture registers, request flag
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_capture_counter  <= cti_pkg::CNT_RST;
      o_rise_capture_reg <= cti_pkg::CNT_RST;
      o_fall_capture_reg <= cti_pkg::CNT_RST;
      o_capture_irq_flag <= 1'b0;
      o_capture_signal   <= 1'b0;
    end else begin
      o_capture_signal <= cap_next;
      // Clear beats a coincident count so width readings start at zero
      if (clr_now) begin
        o_capture_counter <= cti_pkg::CNT_RST;
      end else if (sel_fall) begin
        o_capture_counter <= o_capture_counter + 8'h01;
      end
      if (edge_rise) begin
        o_rise_capture_reg <= o_capture_counter;
      end
      if (edge_fall) begin
        o_fall_capture_reg <= o_capture_counter;
      end
      // Set wins over a software clear in the same cycle
      if (edge_hit) begin
        o_capture_irq_flag <= 1'b1;
      end else if (i_irq_flag_clear) begin
        o_capture_irq_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_fen_seed;
    fen_rise;
  endsequence
  sequence s_seeded;
    filt_ff == $past(seed_lvl);
  endsequence

  count_on_fall_a: assert property (sel_fall && !clr_now |=>
    o_capture_counter == 8'($past(o_capture_counter) + 8'h01))
    else $error("counter missed a falling count edge");
  hold_no_fall_a: assert property (!sel_fall && !clr_now |=>
    $stable(o_capture_counter))
    else $error("counter moved without a count edge");
  clear_on_edge_a: assert property (clr_now |=>
    o_capture_counter == 8'h00)
    else $error("counter not cleared on selected edge");
  rise_capture_a: assert property (edge_rise |=>
    o_rise_capture_reg == $past(o_capture_counter))
    else $error("rise capture register wrong");
  fall_capture_a: assert property (edge_fall |=>
    o_fall_capture_reg == $past(o_capture_counter))
    else $error("fall capture register wrong");
  irq_on_match_a: assert property (edge_hit |=> o_capture_irq_flag)
    else $error("request flag not set by matching edge");
  pin_unused_low_a: assert property (
    !i_capture_pin_select && !i_filter_enable |=> !cap_ff)
    else $error("capture signal not low with pin unassigned");
  filter_agree_a: assert property (
    i_filter_enable && !fen_rise && samp_tick && !lat_all_hi && !lat_all_lo
    |=> $stable(filt_ff))
    else $error("filter output moved without agreement");
  filter_seed_a: assert property (s_fen_seed |=> s_seeded)
    else $error("filter not seeded on enable");
  edge_single_a: assert property ($rose(o_capture_signal) |-> edge_rise)
    else $error("rising pulse missing on capture rise");
  // A select change alone must count when it drops the muxed level
  switch_fall_a: assert property (
    $changed(clk_sel) && selclk_ff && !sel_clk && !clr_now |=>
    o_capture_counter == 8'($past(o_capture_counter) + 8'h01))
    else $error("select switchover to low did not count");
  bypass_direct_a: assert property (
    !i_filter_enable |=> cap_ff == $past(pin_gated))
    else $error("capture signal not direct with filter off");
  filter_pass_a: assert property (
    i_filter_enable && !fen_rise && samp_tick && lat_all_hi |=> filt_ff)
    else $error("filter did not pass agreed high level");
  flag_hold_a: assert property (
    !edge_hit && !i_irq_flag_clear |=> $stable(o_capture_irq_flag))
    else $error("request flag moved without cause");
  flag_clear_a: assert property (
    !edge_hit && i_irq_flag_clear |=> !o_capture_irq_flag)
    else $error("request flag not cleared");
endmodule
`default_nettype wire

// File: cti_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module cti_pulse_src (
  // Clock
  input  wire logic       i_clock,
  // Bench commands
  input  wire logic       i_level,
  input  wire logic       i_glitch_go,
  input  wire logic [7:0] i_glitch_len,
  // Capture pin
  output logic            o_pin
);
  // ****************************************
  // Glitch timer
  // ****************************************
  logic [7:0] glitch_cnt_ff = 8'h00;
  always_ff @(posedge i_clock) begin
    if (i_glitch_go) begin
      glitch_cnt_ff <= i_glitch_len;
    end else if (glitch_cnt_ff != 8'h00) begin
      glitch_cnt_ff <= glitch_cnt_ff - 8'h01;
    end
  end
  // Inverted idle level while running, to probe filter rejection
  assign o_pin = i_level ^ (glitch_cnt_ff != 8'h00);
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic            i_clock, i_rst_n, lvl, g_go, sub, sel, filt, es, fclr;
  logic            c_hi, c_lo, k_hi, k_lo;
  logic [7:0]      base;
  wire logic       pin, irq, sig;
  wire logic [7:0] cnt, rq, fq;
  int              error_cnt, total_checks, cycles;
  // Row: {sel before, sel after, pin before, pin after, edge, flag, sig}
  logic [6:0]      rows [6] = '{7'h3f, 7'h39, 7'h5a, 7'h6f, 7'h72, 7'h0c};
  cti_pulse_src src (.i_clock(i_clock), .i_level(lvl), .i_glitch_go(g_go),
    .i_glitch_len(8'h04), .o_pin(pin));
  cti_input_path dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_capture_pin_port(pin), .i_sub_clock_half(sub),
    .i_capture_pin_select(sel), .i_filter_enable(filt),
    .i_clock_select_hi(c_hi), .i_clock_select_lo(c_lo),
    .i_counter_clear_select_hi(k_hi), .i_counter_clear_select_lo(k_lo),
    .i_interrupt_edge_select(es), .i_irq_flag_clear(fclr),
    .o_capture_counter(cnt), .o_rise_capture_reg(rq),
    .o_fall_capture_reg(fq), .o_capture_irq_flag(irq),
    .o_capture_signal(sig));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic clr_flag();
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Slow watch clock level so the sub-clock input never sits still
  always begin
    repeat (8) @(posedge i_clock);
    #1 sub = ~sub;
  end
  // Hang guard, well above the few hundred cycles of the sequence
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {i_rst_n, lvl, g_go, sub, sel, filt, es, fclr} = 8'h00;
    {c_hi, c_lo, k_hi, k_lo} = 4'h0;
    tick(20);
    chk("counter in reset", 8'h00, cnt);
    chk("captures in reset", 8'h00, rq | fq);
    i_rst_n = 1'b1;
    foreach (rows[i]) begin
      {sel, lvl, es} = {rows[i][6], rows[i][4], rows[i][2]};
      tick(6);
      clr_flag();
      {sel, lvl} = {rows[i][5], rows[i][3]};
      tick(5);
      chk("flag", {7'h00, rows[i][1]}, {7'h00, irq});
      chk("signal", {7'h00, rows[i][0]}, {7'h00, sig});
    end
    // Width measurement on the /2 clock, clearing on both edges
    {c_hi, c_lo, k_hi, k_lo, sel, lvl} = 6'h2e;
    tick(30);
    lvl = 1'b1;
    tick(20);
    lvl = 1'b0;
    tick(30);
    lvl = 1'b1;
    tick(3);
    chk("high width", 8'h01, {7'h00, fq >= 8'h09 && fq <= 8'h0b});
    chk("low width", 8'h01, {7'h00, rq >= 8'h0e && rq <= 8'h10});
    chk("cleared", 8'h01, {7'h00, cnt < 8'h02});
    tick(2);
    // Filter enabled, then pin function set early with pin high
    {sel, es} = 2'h1;
    tick(5);
    filt = 1'b1;
    tick(1);
    clr_flag();
    sel = 1'b1;
    tick(30);
    chk("false rising", 8'h01, {7'h00, irq});
    lvl = 1'b0;
    tick(30);
    clr_flag();
    g_go = 1'b1;
    tick(1);
    g_go = 1'b0;
    tick(30);
    chk("glitch rejected", 8'h00, {7'h00, irq});
    lvl = 1'b1;
    tick(8);
    chk("filter delay", 8'h00, {7'h00, irq});
    tick(22);
    chk("filtered edge", 8'h01, {7'h00, irq});
    // Filter dropped right after a pin fall: the bypass shows it at once
    es = 1'b0;
    clr_flag();
    lvl = 1'b0;
    tick(1);
    chk("no early edge", 8'h00, {7'h00, irq});
    filt = 1'b0;
    tick(5);
    chk("false falling", 8'h01, {7'h00, irq});
    chk("bypass level", 8'h00, {7'h00, sig});
    // Count rate of the /32, sub and /64 clock sources over whole periods
    {c_hi, c_lo} = 2'h1;
    tick(4);
    base = cnt;
    tick(64);
    chk("div32 rate", 8'h02, 8'(cnt - base));
    {c_hi, c_lo} = 2'h3;
    tick(4);
    base = cnt;
    tick(64);
    chk("sub rate", 8'h04, 8'(cnt - base));
    {c_hi, c_lo} = 2'h0;
    tick(4);
    base = cnt;
    tick(128);
    chk("div64 rate", 8'h02, 8'(cnt - base));
    report_and_stop();
  end
endmodule
`default_nettype wire
